// *** hdl/vpi_params.svh ***
// vectored priority interrupt constants: vector map, levels, offsets
// assumes word addressing on the program bus, 21-bit fetch addresses
`ifndef VPI_PARAMS_SVH
`define VPI_PARAMS_SVH

// ****************************************
// widths
// ****************************************
`define VPI_NUM_VEC 66
`define VPI_VEC_W 7
`define VPI_LVL_W 2
`define VPI_ADDR_W 21
`define VPI_BASE_W 16
`define VPI_BASE_SHIFT 7
`define VPI_ENTRY_SHIFT 1
`define VPI_ENTRY_RANGE_W 19

// ****************************************
// levels and special vectors
// ****************************************
`define VPI_LVL_TOP 2'h3
`define VPI_LVL_MID 2'h2
`define VPI_LVL_LOW 2'h1
`define VPI_LVL_ZERO 2'h0
`define VPI_VEC_RESET 7'h00
`define VPI_VEC_WDOG 7'h01
`define VPI_VEC_ILLEGAL 7'h02
`define VPI_VEC_SWI3 7'h03
`define VPI_VEC_STACK 7'h04
`define VPI_VEC_MISALIGN 7'h05
`define VPI_VEC_SWI2 7'h0e
`define VPI_VEC_SWI1 7'h0f
`define VPI_VEC_SWI0 7'h10
`define VPI_BOOT_BASE 16'h0200
`define VPI_BASE_RESET 16'h0000

// per-vector level class: 0 none/reserved, 1 fixed, 2 range 1-3, 3 range 0-2
// core fixed 2-5; debug 6,7,9-11; swi 14-16 fixed; 17-65 peripherals
`define VPI_CLASS_FIXED 2'h1
`define VPI_CLASS_HIGH 2'h2
`define VPI_CLASS_LOW 2'h3
// implemented-vector mask, bit n = vector n
`define VPI_IMPL_MASK 66'h3_fff7_efcf_fdf7_cefc
`endif

// *** hdl/vpi_pkg.sv ***
// vectored priority interrupt types
// assumes vpi_params.svh in the include path
`include "vpi_params.svh"
package vpi_pkg;
  typedef struct packed {
    logic valid;
    logic [`VPI_LVL_W-1:0] level;
    logic [`VPI_VEC_W-1:0] vector;
  } vpi_grant_t;

  typedef struct packed {
    logic valid;
    logic [`VPI_VEC_W-1:0] vector;
    logic [`VPI_ADDR_W-1:0] addr;
  } vpi_fetch_t;

  typedef enum logic [1:0] {
    VPI_IDLE = 2'b00,
    VPI_OFFER = 2'b01,
    VPI_WAIT_DROP = 2'b10
  } vpi_state_t;
endpackage

// *** hdl/vpi_arbiter.sv ***
// vectored priority interrupt arbiter: level first, then lowest vector
// assumes pending bits already masked to implemented vectors
`timescale 1ns/100ps
`include "vpi_params.svh"
module vpi_arbiter
  import vpi_pkg::*;
(
  // requests
  input wire logic [`VPI_NUM_VEC-1:0] pend,
  input wire logic [2*`VPI_NUM_VEC-1:0] levels,
  // winner
  output vpi_grant_t grant
);
  // ****************************************
  // per-level scan
  // ****************************************
  logic [3:0] lvl_any;
  logic [`VPI_VEC_W-1:0] lvl_vec [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lvl
      logic [`VPI_NUM_VEC-1:0] hit;
      always_comb begin
        for (int i = 0; i < `VPI_NUM_VEC; i++) begin
          hit[i] = pend[i] && (levels[2*i +: 2] == 2'(g));
        end
      end
      // highest index first so lowest vector wins [RL2]
      always_comb begin
        lvl_vec[g] = 7'h00;
        for (int i = `VPI_NUM_VEC - 1; i >= 0; i--) begin
          if (hit[i]) begin
            lvl_vec[g] = 7'(i);
          end
        end
      end
      assign lvl_any[g] = |hit;
    end
  endgenerate

  // ****************************************
  // level selection, 3 down to 0
  // ****************************************
  wire sel3 = lvl_any[3];
  wire sel2 = !sel3 && lvl_any[2];
  wire sel1 = !sel3 && !lvl_any[2] && lvl_any[1];
  assign grant.valid = |lvl_any;
  assign grant.level = sel3 ? 2'h3 : sel2 ? 2'h2 : sel1 ? 2'h1 : 2'h0; // [RL1]
  assign grant.vector = sel3 ? lvl_vec[3] : sel2 ? lvl_vec[2] :
                        sel1 ? lvl_vec[1] : lvl_vec[0]; // [RL1]
endmodule

// *** hdl/vpi_ctrl.sv ***
// vectored priority interrupt controller top
// assumes synchronous request inputs and a core that acknowledges fetches
// How it works
// RL1: higher level always serviced before lower
// RL2: equal level, lowest vector number wins
// RL3: ranged sources take software level within range
// RL4: fetch address is base plus vector offset
// RL5: slots zero and one are reset overlays
// RL6: table holds jumps there, calls elsewhere
// RL7: core exceptions fixed at level three
// RL8: debug sources take level one to three
// RL9: external, low-voltage, clock sources level zero-two
// RL10: flash raises three requests, levels zero-two
// RL11: both spi ports raise full and empty
// RL12: serial port raises four requests, 44 reserved
// RL13: decoders raise home and index requests
// RL14: entries two words, 19-bit reach
// RL15: boot base makes slots reset addresses
// RL16: request pends until acknowledged or withdrawn
`timescale 1ns/100ps
`include "vpi_params.svh"
module vpi_ctrl
  import vpi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request sources, bit n is vector n
  input wire logic [`VPI_NUM_VEC-1:0] req,
  // software level setting, two bits per vector
  input wire logic [2*`VPI_NUM_VEC-1:0] level_cfg,
  input wire logic [`VPI_BASE_W-1:0] vector_base,
  // core side
  input wire logic core_mask_lvl_en,
  input wire logic [`VPI_LVL_W-1:0] core_mask_lvl,
  input wire logic fetch_ack,
  output logic irq_valid,
  output logic [`VPI_VEC_W-1:0] irq_vector,
  output logic [`VPI_LVL_W-1:0] irq_level,
  output logic [`VPI_ADDR_W-1:0] irq_addr,
  output logic boot_overlay
);
  // ****************************************
  // per-vector class table
  // ****************************************
  // implemented vectors, reserved slots never pend
  localparam logic [`VPI_NUM_VEC-1:0] IMPL = `VPI_IMPL_MASK;
  function automatic logic [1:0] vec_class(input int v);
    logic [1:0] c;
    c = 2'h0;
    if (v >= 2 && v <= 5) begin
      c = `VPI_CLASS_FIXED; // [RL7]
    end else if (v == 6 || v == 7 || (v >= 9 && v <= 11)) begin
      c = `VPI_CLASS_HIGH; // [RL8]
    end else if (v >= 14 && v <= 16) begin
      c = `VPI_CLASS_FIXED;
    end else if (v >= 17) begin
      c = `VPI_CLASS_LOW; // [RL9] [RL10] [RL11] [RL12] [RL13]
    end
    if (!IMPL[v]) begin
      c = 2'h0; // reserved slots incl. 44 [RL5] [RL12]
    end
    return c;
  endfunction

  function automatic logic [1:0] fixed_level(input int v);
    logic [1:0] l;
    l = `VPI_LVL_TOP;
    if (v == 14) begin
      l = `VPI_LVL_MID;
    end else if (v == 15) begin
      l = `VPI_LVL_LOW;
    end else if (v == 16) begin
      l = `VPI_LVL_ZERO;
    end
    return l;
  endfunction

  // ****************************************
  // effective level and pending per vector
  // ****************************************
  logic [2*`VPI_NUM_VEC-1:0] eff_lvl;
  logic [`VPI_NUM_VEC-1:0] pend_q;
  logic [`VPI_NUM_VEC-1:0] pend_d;
  logic [`VPI_NUM_VEC-1:0] ack_hot;
  logic [`VPI_NUM_VEC-1:0] gated;
  genvar g;
  generate
    for (g = 0; g < `VPI_NUM_VEC; g++) begin : g_vec
      localparam logic [1:0] CLS = vec_class(g);
      wire [1:0] sw = level_cfg[2*g +: 2];
      wire [1:0] lvl;
      if (CLS == `VPI_CLASS_FIXED) begin : g_fix
        assign lvl = fixed_level(g); // [RL7]
      end else if (CLS == `VPI_CLASS_HIGH) begin : g_hi
        assign lvl = (sw == 2'h0) ? `VPI_LVL_LOW : sw; // clamp to 1-3 [RL3] [RL8]
      end else begin : g_lo
        assign lvl = (sw == 2'h3) ? `VPI_LVL_MID : sw; // clamp to 0-2 [RL3] [RL9]
      end
      assign eff_lvl[2*g +: 2] = lvl;
      // pending while source asserts, cleared by ack, ack wins [RL16]
      assign pend_d[g] = (CLS != 2'h0) && req[g] && !(ack_hot[g] && pend_q[g]);
      assign gated[g] = pend_q[g] && (!core_mask_lvl_en || lvl >= core_mask_lvl);
    end
  endgenerate

  // ****************************************
  // arbitration
  // ****************************************
  vpi_grant_t win;
  vpi_arbiter u_arb (
    .pend(gated),
    .levels(eff_lvl),
    .grant(win)
  );

  // ****************************************
  // address forming
  // ****************************************
  wire [`VPI_ADDR_W-1:0] base_addr = {5'h00, vector_base} << `VPI_BASE_SHIFT;
  wire [`VPI_ADDR_W-1:0] offs = `VPI_ADDR_W'({win.vector, 1'b0}); // [RL14]
  wire [`VPI_ADDR_W-1:0] fetch_addr = base_addr + offs; // [RL4]
  wire is_boot = (vector_base == `VPI_BOOT_BASE); // [RL15]

  // ****************************************
  // offer handshake
  // ****************************************
  vpi_state_t state_q;
  vpi_state_t state_d;
  wire take = (state_q == VPI_OFFER) && fetch_ack;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      VPI_IDLE: begin
        if (win.valid) begin
          state_d = VPI_OFFER;
        end
      end
      VPI_OFFER: begin
        if (fetch_ack) begin
          state_d = VPI_WAIT_DROP;
        end else if (!win.valid) begin
          state_d = VPI_IDLE; // source withdrew [RL16]
        end
      end
      VPI_WAIT_DROP: begin
        state_d = VPI_IDLE;
      end
      default: begin
        state_d = VPI_IDLE; // unused code falls back to idle
      end
    endcase
  end
  // one-hot acknowledge of the offered vector
  always_comb begin
    ack_hot = '0;
    if (take) begin
      ack_hot[irq_vector] = 1'b1; // [RL16]
    end
  end

  // state, pending
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= VPI_IDLE;
      pend_q <= '0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
    end
  end

  // registered outputs, refreshed while offering so a higher winner preempts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_valid <= 1'b0;
      irq_vector <= 7'h00;
      irq_level <= 2'h0;
      irq_addr <= 21'h00000;
      boot_overlay <= 1'b0;
    end else begin
      irq_valid <= win.valid && state_d == VPI_OFFER && !take;
      if (!take) begin
        irq_vector <= win.vector; // [RL1] [RL2]
        irq_level <= win.level;
        irq_addr <= fetch_addr; // [RL4]
      end
      boot_overlay <= is_boot; // [RL5] [RL15]
    end
  end
endmodule

// *** dv/vpi_ctrl_assertions.sv ***
// port checker for the vectored interrupt controller
// assumes one clock domain, bound onto vpi_ctrl
`timescale 1ns/100ps
`include "vpi_params.svh"
module vpi_ctrl_assertions
  import vpi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request side
  input wire logic [`VPI_NUM_VEC-1:0] req,
  input wire logic [`VPI_BASE_W-1:0] vector_base,
  input wire logic fetch_ack,
  input wire logic core_mask_lvl_en,
  input wire logic [`VPI_LVL_W-1:0] core_mask_lvl,
  // offer side
  input wire logic irq_valid,
  input wire logic [`VPI_VEC_W-1:0] irq_vector,
  input wire logic [`VPI_LVL_W-1:0] irq_level,
  input wire logic [`VPI_ADDR_W-1:0] irq_addr,
  input wire logic boot_overlay
);
  localparam logic [`VPI_NUM_VEC-1:0] IMPL = `VPI_IMPL_MASK;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ********
  // offer checks
  // ********
  addr_formed_a: assert property (irq_valid && $stable(vector_base) |->
    irq_addr == ({5'h0, vector_base} << 7) + {13'h0, irq_vector, 1'b0})
    else $error("fetch address wrong");
  resv_never_a: assert property (irq_valid |-> IMPL[irq_vector])
    else $error("reserved vector offered");
  dbg_range_a: assert property (
    irq_valid && irq_vector inside {6, 7, [9:11]} |-> irq_level != 2'h0)
    else $error("debug level out of range");
  periph_range_a: assert property (
    irq_valid && irq_vector >= 7'h11 |-> irq_level != 2'h3)
    else $error("peripheral level out of range");
  top_first_a: assert property (
    irq_valid && |($past(req[5:2], 2) & $past(req[5:2])) |-> irq_level == 2'h3)
    else $error("level three not first");
  dead_gap_a: assert property (fetch_ack && irq_valid |=> !irq_valid [*2])
    else $error("offer too soon after ack");
  offer_lat_a: assert property ($rose(irq_valid) |-> $past(|(req & IMPL), 2))
    else $error("offer without request");
  boot_flag_a: assert property (
    ##1 boot_overlay == ($past(vector_base) == `VPI_BOOT_BASE))
    else $error("boot overlay flag wrong");
  mask_floor_a: assert property (
    irq_valid && $past(core_mask_lvl_en) |-> irq_level >= $past(core_mask_lvl))
    else $error("offer below mask level");
endmodule
bind vpi_ctrl vpi_ctrl_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .req(req),
  .vector_base(vector_base), .fetch_ack(fetch_ack),
  .core_mask_lvl_en(core_mask_lvl_en), .core_mask_lvl(core_mask_lvl), .irq_valid(irq_valid),
  .irq_vector(irq_vector), .irq_level(irq_level), .irq_addr(irq_addr),
  .boot_overlay(boot_overlay));

// *** dv/vpi_core_model.sv ***
// core model: accepts each offered vector after a set delay
// assumes registered offer outputs from the controller
`timescale 1ns/100ps
module vpi_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // offer and acceptance
  input wire logic irq_valid,
  input wire logic [6:0] irq_vector,
  input wire logic [3:0] ack_dly,
  output logic fetch_ack,
  output logic fetch_call
);
  logic [3:0] wait_q;
  logic [65:0] call_slot;
  // table as software fills it: jumps in the two overlay slots, calls elsewhere
  assign call_slot = {{64{1'b1}}, 2'b00};
  // count offer cycles, pulse ack; report whether the fetched slot holds a call
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      fetch_ack <= 1'b0;
      fetch_call <= 1'b0;
    end else begin
      fetch_ack <= irq_valid && !fetch_ack && wait_q >= ack_dly;
      fetch_call <= call_slot[irq_vector];
      wait_q <= (irq_valid && !fetch_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// *** dv/vpi_ctrl_tb.sv ***
// testbench for the vectored interrupt controller
// assumes the core model and the bound port checker
`timescale 1ns/100ps
`include "vpi_params.svh"
module vpi_ctrl_tb
  import vpi_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [`VPI_NUM_VEC-1:0] req = '0;
  logic [2*`VPI_NUM_VEC-1:0] level_cfg = '0;
  logic [15:0] vector_base = 16'h0010;
  logic [3:0] ack_dly = 4'h1;
  logic mask_en = 1'b0;
  logic [1:0] mask_lvl = 2'h0;
  logic fetch_ack, fetch_call, irq_valid, boot_overlay;
  logic [6:0] irq_vector;
  logic [1:0] irq_level;
  logic [20:0] irq_addr;
  int bad_count = 0;
  int checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  vpi_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .req(req), .level_cfg(level_cfg),
    .vector_base(vector_base), .core_mask_lvl_en(mask_en), .core_mask_lvl(mask_lvl),
    .fetch_ack(fetch_ack), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_level(irq_level), .irq_addr(irq_addr), .boot_overlay(boot_overlay));
  vpi_core_model u_core (.clk_sys(clk_sys), .rst(rst), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .ack_dly(ack_dly), .fetch_ack(fetch_ack),
    .fetch_call(fetch_call));
  // ********
  // helpers
  // ********
  task automatic chk(string nm, logic [20:0] exp, logic [20:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic arm(int v, logic [1:0] l);
    level_cfg[2*v +: 2] = l;
    req[v] = 1'b1;
  endtask
  // wait for the core ack, judge the offer, withdraw the source
  task automatic serve(int v, logic [1:0] l);
    int i;
    i = 0;
    do begin
      step(1);
      i++;
    end while (fetch_ack !== 1'b1 && i < 50);
    chk("ack", 21'h1, 21'(fetch_ack));
    if (fetch_ack !== 1'b1)
      tally_and_finish();
    chk("call slot", 21'h1, 21'(fetch_call));
    chk("vector", 21'(v), 21'(irq_vector));
    chk("level", 21'(l), 21'(irq_level));
    chk("addr", ({5'h0, vector_base} << 7) + 21'(2 * v), irq_addr);
    req[v] = 1'b0;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_order();
    arm(3, 2'h0);
    arm(6, 2'h1);
    arm(17, 2'h2);
    arm(18, 2'h2);
    arm(20, 2'h0);
    arm(47, 2'h2);
    serve(3, 2'h3);
    serve(17, 2'h2);
    serve(18, 2'h2);
    serve(47, 2'h2);
    serve(6, 2'h1);
    serve(20, 2'h0);
    $display("t_order done");
  endtask
  task automatic t_clamp();
    req[1:0] = 2'h3;
    req[8] = 1'b1;
    req[44] = 1'b1;
    arm(6, 2'h0);
    arm(22, 2'h3);
    arm(23, 2'h2);
    arm(24, 2'h1);
    serve(22, 2'h2);
    serve(23, 2'h2);
    serve(6, 2'h1);
    serve(24, 2'h1);
    step(10);
    chk("idle", 21'h0, 21'(irq_valid));
    req = '0;
    $display("t_clamp done");
  endtask
  task automatic t_ports();
    for (int v = 38; v <= 50; v++)
      arm(v, 2'h0);
    for (int v = 38; v <= 50; v++)
      if (v != 44)
        serve(v, 2'h0);
    req = '0;
    $display("t_ports done");
  endtask
  task automatic t_boot();
    vector_base = `VPI_BOOT_BASE;
    step(3);
    chk("boot", 21'h1, 21'(boot_overlay));
    arm(2, 2'h0);
    serve(2, 2'h3);
    vector_base = 16'h0010;
    step(3);
    chk("boot", 21'h0, 21'(boot_overlay));
    $display("t_boot done");
  endtask
  task automatic t_mask();
    mask_en = 1'b1;
    mask_lvl = 2'h2;
    arm(20, 2'h1);
    arm(21, 2'h2);
    serve(21, 2'h2);
    step(10);
    chk("masked", 21'h0, 21'(irq_valid));
    mask_en = 1'b0;
    serve(20, 2'h1);
    mask_lvl = 2'h0;
    $display("t_mask done");
  endtask
  task automatic t_withdraw();
    ack_dly = 4'hf;
    arm(21, 2'h1);
    step(3);
    chk("held", 21'h1, 21'(irq_valid));
    req[21] = 1'b0;
    step(3);
    chk("dropped", 21'h0, 21'(irq_valid));
    ack_dly = 4'h1;
    $display("t_withdraw done");
  endtask
  initial begin
    step(6);
    rst = 1'b0;
    step(1);
    t_order();
    t_clamp();
    t_ports();
    t_boot();
    t_mask();
    t_withdraw();
    tally_and_finish();
  end
endmodule
